//--- design/spio_port.sv
// Shared parallel I/O port: registers, pin read path and pad drive
// Notes on behaviour
// - Active peripheral disables port driver, pin readable
// - Enabled but idle peripheral lets port drive
// - Direction bit one makes pin input
// - Reset sets all pins to inputs
// - Latch read returns latch, write updates latch
// - Pin read returns pins, write updates latch
// - Unimplemented bits read zero everywhere
// - Input-only shared pin is dedicated port bit
// - Mux pair picks peripheral or port, peripheral first
// - First port direction also steers interrupt, reference pins; here extra_oe is held at zero instead
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module spio_port (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [15:0] rdata,
  // Pads
  input  wire logic [15:0] pad_in,
  output logic      [15:0] pad_out,
  output logic      [15:0] pad_oe,
  // Extra first-port pins: interrupt and reference
  input  wire logic [3:0]  extra_in,
  output logic      [3:0]  extra_oe,
  // Peripherals
  input  wire logic [15:0] per_en,
  input  wire logic [15:0] per_active,
  input  wire logic [15:0] per_out,
  input  wire logic [15:0] per_oe
);
  logic [15:0] dir_reg;
  logic [15:0] output_latch_reg;
  logic [15:0] pins_reg;
  logic [3:0]  fdir_reg;
  logic [3:0]  extra_reg;

  spio_pad_if pif ();

  function automatic logic [15:0] impl(input logic [15:0] v);
    return v & spio_pkg::IMPL_MASK;
  endfunction

  // Direction register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dir_reg  <= spio_pkg::DIR_RST;
      fdir_reg <= spio_pkg::FDIR_RST;
    end else if (wr_stb) begin
      if (addr == spio_pkg::OFF_DIR) begin
        dir_reg <= impl(wdata);
      end else if (addr == spio_pkg::OFF_FDIR) begin
        fdir_reg <= wdata[3:0];
      end
    end
  end

  // Output latch, written through latch or pin-value address
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      output_latch_reg <= spio_pkg::LATCH_RST;
    end else if (wr_stb) begin
      if (addr == spio_pkg::OFF_LATCH) begin
        output_latch_reg <= impl(wdata);
      end else if (addr == spio_pkg::OFF_PINS) begin
        output_latch_reg <= impl(wdata);
      end
    end
  end

  // Pin sampling, always readable even when a peripheral drives
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pins_reg  <= 16'h0000;
      extra_reg <= 4'h0;
    end else begin
      pins_reg  <= impl(pad_in);
      extra_reg <= extra_in;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (rd_stb) begin
      if (addr == spio_pkg::OFF_DIR) begin
        rdata <= impl(dir_reg);
      end else if (addr == spio_pkg::OFF_PINS) begin
        rdata <= pins_reg;
      end else if (addr == spio_pkg::OFF_LATCH) begin
        rdata <= impl(output_latch_reg);
      end else if (addr == spio_pkg::OFF_FDIR) begin
        rdata <= {8'h00, extra_reg, fdir_reg};
      end else begin
        rdata <= 16'h0000;
      end
    end else begin
      rdata <= 16'h0000;
    end
  end

  // Port side drive toward the muxes
  assign pif.port_out   = impl(output_latch_reg);
  assign pif.port_oe    = impl(~dir_reg);
  assign pif.per_en     = impl(per_en);
  assign pif.per_active = per_active;
  assign pif.per_out    = per_out;
  assign pif.per_oe     = per_oe;

  spio_pad_mux u_mux (
    .p (pif.mux)
  );

  assign pad_out = pif.pad_out;
  assign pad_oe  = pif.pad_oe;
  // Input-only shared pins: no competing source, enable held at zero
  assign extra_oe = ~fdir_reg & {4{~dir_reg[spio_pkg::FIRST_W-1]}} & 4'h0;
endmodule // spio_port
`default_nettype wire

//--- design/spio_pkg.sv
// Package of constants for the shared parallel I/O port
package spio_pkg;
  localparam int unsigned WIDTH      = 16;
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned FIRST_W    = 8;
  localparam int unsigned EXTRA_W    = 4;
  // Register offsets (byte addresses)
  localparam logic [3:0] OFF_DIR     = 4'h0;
  localparam logic [3:0] OFF_PINS    = 4'h4;
  localparam logic [3:0] OFF_LATCH   = 4'h8;
  localparam logic [3:0] OFF_FDIR    = 4'hc;
  // Reset values
  localparam logic [15:0] DIR_RST    = 16'hffff;
  localparam logic [15:0] LATCH_RST  = 16'h0000;
  localparam logic [3:0]  FDIR_RST   = 4'hf;
  // Bits present on this variant (others read zero)
  localparam logic [15:0] IMPL_MASK  = 16'hffff;
endpackage : spio_pkg

//--- design/spio_pad_if.sv
// Interface carrying per-bit port and peripheral drive toward the pad mux
`timescale 1ns/1ps
`default_nettype none
interface spio_pad_if;
  logic [15:0] port_out;
  logic [15:0] port_oe;
  logic [15:0] per_en;
  logic [15:0] per_active;
  logic [15:0] per_out;
  logic [15:0] per_oe;
  logic [15:0] pad_out;
  logic [15:0] pad_oe;
  modport ctl (output port_out, output port_oe, output per_en, output per_active,
               output per_out, output per_oe, input pad_out, input pad_oe);
  modport mux (input port_out, input port_oe, input per_en, input per_active,
               input per_out, input per_oe, output pad_out, output pad_oe);
endinterface : spio_pad_if
`default_nettype wire

//--- design/spio_pad_mux.sv
// Output data and enable multiplexers between peripheral and port
`timescale 1ns/1ps
`default_nettype none
module spio_pad_mux (
  spio_pad_if.mux p
);
  logic [15:0] own;
  // Peripheral owns the pad only while enabled and actively driving
  assign own       = p.per_en & p.per_active;
  assign p.pad_out = (own & p.per_out) | (~own & p.port_out);
  assign p.pad_oe  = (own & p.per_oe) | (~own & p.port_oe);
endmodule // spio_pad_mux
`default_nettype wire

//--- verification/spio_props.sv
// Checker for the shared parallel I/O port
`timescale 1ns/1ps
`default_nettype none
module spio_props (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  input wire logic [3:0]  extra_oe,
  input wire logic [15:0] per_en,
  input wire logic [15:0] per_active,
  input wire logic [15:0] per_out,
  input wire logic [15:0] per_oe
);
  wire  [15:0] own = per_en & per_active;
  logic [1:0]  up_reg;
  always_ff @(posedge clk_sys) begin
    up_reg <= !rst_n ? 2'h0 : (up_reg == 2'h3 ? up_reg : up_reg + 2'h1);
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_OWN_OE: assert property (((pad_oe ^ per_oe) & own) == 16'h0)
    else $error("pad enable not from peripheral");
  AST_OWN_OUT: assert property (((pad_out ^ per_out) & own) == 16'h0)
    else $error("pad data not from peripheral");
  AST_RST_IN: assert property (!$past(rst_n) |-> (pad_oe & ~own) == 16'h0)
    else $error("port drives after reset");
  AST_EXTRA: assert property (extra_oe == 4'h0)
    else $error("input-only pin driven");
  AST_DIR_OE: assert property (wr_stb && addr == 4'h0 |=> (pad_oe & ~own) == (~$past(wdata) & ~own))
    else $error("pad enable not from direction");
  AST_LAT_OUT: assert property (wr_stb && (addr == 4'h8 || addr == 4'h4)
    |=> ((pad_out ^ $past(wdata)) & ~own) == 16'h0) else $error("pad data not latch");
  AST_LATCH_RD: assert property (up_reg == 2'h3 && $past(wr_stb && addr == 4'h8, 3) && !$past(wr_stb, 2)
    && $past(rd_stb && addr == 4'h8) |-> rdata == $past(wdata, 3)) else $error("latch read");
  AST_PIN_WR: assert property (up_reg == 2'h3 && $past(wr_stb && addr == 4'h4, 3) && !$past(wr_stb, 2)
    && $past(rd_stb && addr == 4'h8) |-> rdata == $past(wdata, 3)) else $error("pin write");
endmodule // spio_props
bind spio_port spio_props u_props (.clk_sys, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
  .pad_out, .pad_oe, .extra_oe, .per_en, .per_active, .per_out, .per_oe);
`default_nettype wire

//--- verification/spio_pad_model.sv
// Pad cell model: pin follows pad drive (port or peripheral), else outside level
`timescale 1ns/1ps
`default_nettype none
module spio_pad_model (
  // Pad side
  input  wire logic [15:0] pad_out,
  input  wire logic [15:0] pad_oe,
  input  wire logic [15:0] ext,
  output logic      [15:0] pad_in
);
  assign pad_in = (pad_out & pad_oe) | (ext & ~pad_oe);
endmodule // spio_pad_model
`default_nettype wire

//--- verification/shared_parallel_io_port_test.sv
// Self-checking bench for the shared parallel I/O port
`timescale 1ns/1ps
`default_nettype none
module shared_parallel_io_port_test;
  logic        clk_sys = 1'h0, rst_n = 1'h0, wr_stb = 1'h0, rd_stb = 1'h0;
  logic [3:0]  addr = 4'h0, extra_in = 4'ha, extra_oe;
  logic [15:0] wdata = '0, rdata, pad_in, pad_out, pad_oe, ext = '0, v;
  logic [15:0] per_en = '0, per_active = '0, per_out = '0, per_oe = '0;
  int          fail_count = 0, tests_run = 0, cyc = 0;
  always #2 clk_sys = ~clk_sys;
  spio_pad_model pads (.pad_out, .pad_oe, .ext, .pad_in);
  spio_port dut (.clk_sys, .rst_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .pad_in, .pad_out,
    .pad_oe, .extra_in, .extra_oe, .per_en, .per_active, .per_out, .per_oe);
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %0t %h %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'h1;
    @(posedge clk_sys);
    wr_stb <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'h1;
    @(posedge clk_sys);
    rd_stb <= 1'h0;
    #1 v = rdata;
  endtask
  task automatic print_verdict;
    if (fail_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_reset;
    rd(4'h0);
    chk(v, 16'hffff);
    chk(pad_oe, 16'h0000);
    rd(4'hc);
    chk(v, 16'h00af);
    chk({12'h000, extra_oe}, 16'h0000);
  endtask
  task automatic t_regs;
    wr(4'h8, 16'ha5c3);
    rd(4'h8);
    chk(v, 16'ha5c3);
    wr(4'h4, 16'h1234);
    rd(4'h8);
    chk(v, 16'h1234);
    @(posedge clk_sys);
    ext <= 16'h5a5a;
    rd(4'h4);
    chk(v, 16'h5a5a);
    rd(4'h2);
    chk(v, 16'h0000);
  endtask
  task automatic t_drive;
    wr(4'h0, 16'h0000);
    chk(pad_oe, 16'hffff);
    chk(pad_out, 16'h1234);
    @(posedge clk_sys);
    per_en <= 16'hffff;
    per_active <= 16'h00ff;
    per_out <= 16'h0f0f;
    per_oe <= 16'h00f0;
    #1 chk(pad_out, 16'h120f);
    chk(pad_oe, 16'hfff0);
    rd(4'h4);
    chk(v, 16'h120a);
    wr(4'h0, 16'h0f00);
    chk(pad_oe, 16'hf0f0);
    chk({12'h000, extra_oe}, 16'h0000);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 500) begin
      fail_count++;
      print_verdict;
    end
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'h1;
    t_reset;
    t_regs;
    t_drive;
    print_verdict;
  end
endmodule // shared_parallel_io_port_test
`default_nettype wire
